// File: src/audio_mixer_eq_routing_regs.svh
// Register word indices, field positions, reset values and cycle costs
// Assumes byte address = 4 * word index on the register bus
`ifndef AUDIO_MIXER_EQ_ROUTING_REGS_SVH
`define AUDIO_MIXER_EQ_ROUTING_REGS_SVH

// Mixer input words, one word per input, four consecutive words per mixer
`define MIX_PORT1_BASE 12'h700
`define MIX_PORT2_BASE 12'h740
`define MIX_PORT3_BASE 12'h780
`define MIX_OUTPUT_PATH_ONE_BASE  12'h680
`define MIX_OUTPUT_FOUR_LEFT_BASE 12'h688
`define MIX_EQ1_BASE   12'h880
`define MIX_EQ2_BASE   12'h884

// Mixer input word fields
`define SRC_LSB        16
`define STS_BIT        15
`define VOL_LSB        1

// Equaliser control and coefficient words
`define FX_STATUS      12'he01
`define EQ1_CTL1       12'he10
`define EQ1_CTL2       12'he11
`define EQ1_COEF       12'he12
`define EQ2_CTL1       12'he26
`define EQ2_CTL2       12'he27
`define EQ2_COEF       12'he28
`define EQ_NCOEF       19
`define FX_EQ_STS_LSB  12

// Clock budget words
`define CLK_ERR        12'ha00
`define CLK_BUDGET     12'ha01

// Source select codes
`define SRC_SILENCE    8'h00
`define SRC_AEC        8'h08
`define SRC_IN_BASE    8'h10
`define SRC_P1_BASE    8'h20
`define SRC_P2_BASE    8'h28
`define SRC_P3_BASE    8'h30

// Reset values and limits
`define VOL_RST        7'h40
`define VOL_MIN        7'h20
`define VOL_MAX        7'h50
`define GAIN_RST       5'b01100
`define BUDGET_RST     16'h0100
`define MIX_COST       16'h0010
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// File: src/audio_mixer_eq_pkg.sv
// Types shared by the mixer, equaliser routing block and its users
// Assumes a single core clock domain for all carriers
package audio_mixer_eq_pkg;

   typedef logic signed [23:0] sample_t;

   typedef enum logic {BAND_SHELF, BAND_PEAK} band_mode_e;

   typedef struct packed {
      logic [7:0] src;
      logic [6:0] vol;
   } mix_in_s;

   typedef struct packed {
      sample_t       aec;
      sample_t [3:0] in_path;
      sample_t [7:0] port1;
      sample_t [5:0] port2;
      sample_t [1:0] port3;
   } src_bus_s;

   typedef struct packed {
      logic        awvalid;
      logic [13:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [13:0] araddr;
      logic        rready;
   } axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_s;

   typedef struct packed {
      logic                  ena;
      band_mode_e [4:0]      mode;
      logic [4:0][4:0]       gain;
      logic [18:0][15:0]     coeff;
   } eq_cfg_s;

   typedef struct packed {
      mix_in_s [6:0][3:0]     mix;
      logic [6:0]             en;
      logic                   err;
      logic [15:0]            budget;
      logic [1:0]             eq_ena;
      logic [1:0]             eq_b1peak;
      logic [1:0][4:0][4:0]   gain;
      logic [1:0][18:0][15:0] coeff;
      logic                   aw_have;
      logic [13:0]            awaddr;
      logic                   w_have;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      sample_t [6:0]          mix_out;
      logic                   out_valid;
   } state_s;

endpackage : audio_mixer_eq_pkg

// File: src/audio_mixer_eq_routing.sv
// Digital core mixers: five output mixers, two equaliser input mixers
// Assumes sources and SAMPLE_EN come from logic on CLK; AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "audio_mixer_eq_routing_regs.svh"

module audio_mixer_eq_routing (
   input  wire logic                               CLK,
   input  wire logic                               SRST,
   input  wire audio_mixer_eq_pkg::axil_req_s      AXI_REQ,
   output      audio_mixer_eq_pkg::axil_rsp_s      AXI_RSP,
   input  wire logic                               SAMPLE_EN,
   input  wire audio_mixer_eq_pkg::src_bus_s       SOURCES,
   output      audio_mixer_eq_pkg::sample_t [6:0]  MIX_OUT,
   output      logic                               MIX_OUT_VALID,
   output      audio_mixer_eq_pkg::eq_cfg_s [1:0]  EQ_CFG,
   output      logic [6:0]                         MIX_ENABLED,
   output      logic                               UNDERCLOCKED
);
   import audio_mixer_eq_pkg::*;

   state_s             st;
   state_s             next_st;
   logic [11:0]        wr_idx;
   logic [11:0]        rd_idx;
   logic [32:0]        wr_old;
   logic [32:0]        rd_val;
   logic [31:0]        wr_val;
   logic               err_set;
   logic               err_clr;
   logic               any_src;
   logic               hit;
   logic [19:0]        used;
   logic [2:0]         n_en;
   logic signed [33:0] acc;

   // Mixer index to control word base
   function automatic logic [11:0] mix_base(input int m);
      case (m)
         0:       return `MIX_PORT1_BASE;
         1:       return `MIX_PORT2_BASE;
         2:       return `MIX_PORT3_BASE;
         3:       return `MIX_OUTPUT_PATH_ONE_BASE;
         4:       return `MIX_OUTPUT_FOUR_LEFT_BASE;
         5:       return `MIX_EQ1_BASE;
         default: return `MIX_EQ2_BASE;
      endcase
   endfunction : mix_base

   // Source code to sample; unknown codes give silence
   function automatic sample_t src_pick(input src_bus_s b, input logic [7:0] c);
      sample_t s;
      s = '0;
      if (c == `SRC_AEC)
         s = b.aec;
      else if (c >= `SRC_IN_BASE && c < `SRC_IN_BASE + 8'h04)
         s = b.in_path[2'(c - `SRC_IN_BASE)];
      else if (c >= `SRC_P1_BASE && c < `SRC_P1_BASE + 8'h08)
         s = b.port1[3'(c - `SRC_P1_BASE)];
      else if (c >= `SRC_P2_BASE && c < `SRC_P2_BASE + 8'h06)
         s = b.port2[3'(c - `SRC_P2_BASE)];
      else if (c >= `SRC_P3_BASE && c < `SRC_P3_BASE + 8'h02)
         s = b.port3[1'(c - `SRC_P3_BASE)];
      return s;
   endfunction : src_pick

   // Volume code to scaled sample, 1dB per step, 2^(r/6) mantissa
   function automatic logic signed [31:0] apply_gain(input sample_t s, input logic [6:0] v);
      logic [6:0]         c;
      logic [5:0]         d;
      logic [3:0]         q;
      logic [2:0]         r;
      logic signed [16:0] mant;
      logic signed [41:0] p;
      c = (v < `VOL_MIN) ? `VOL_MIN : ((v > `VOL_MAX) ? `VOL_MAX : v);
      d = 6'(c - `VOL_MIN) + 6'd4;
      q = 4'(d / 6'd6);
      r = 3'(d % 6'd6);
      case (r)
         3'd0:    mant = 17'sd16384;
         3'd1:    mant = 17'sd18390;
         3'd2:    mant = 17'sd20643;
         3'd3:    mant = 17'sd23170;
         3'd4:    mant = 17'sd26008;
         default: mant = 17'sd29193;
      endcase
      p = 42'(s * mant) >>> 14;
      if (q >= 4'd6)
         p = p <<< (q - 4'd6);
      else
         p = p >>> (4'd6 - q);
      return 32'(p);
   endfunction : apply_gain

   // Register read decode: bit 32 marks a mapped word
   function automatic logic [32:0] reg_read(input state_s s, input logic [11:0] idx);
      logic [32:0] r;
      logic        sts;
      r = '0;
      for (int m = 0; m < 7; m++)
      begin
         for (int n = 0; n < 4; n++)
         begin
            if (idx == mix_base(m) + 12'(n))
            begin
               sts = s.en[m] && (s.mix[m][n].src != `SRC_SILENCE);
               r = {1'b1, 8'h00, s.mix[m][n].src, sts, 7'h00, s.mix[m][n].vol, 1'b0};
            end
         end
      end
      for (int e = 0; e < 2; e++)
      begin
         if (idx == (e == 0 ? `EQ1_CTL1 : `EQ2_CTL1))
            r = {17'h10000, s.gain[e][0], s.gain[e][1], s.gain[e][2], s.eq_ena[e]};
         if (idx == (e == 0 ? `EQ1_CTL2 : `EQ2_CTL2))
            r = {17'h10000, s.gain[e][3], s.gain[e][4], 5'h00, s.eq_b1peak[e]};
         for (int k = 0; k < `EQ_NCOEF; k++)
         begin
            if (idx == (e == 0 ? `EQ1_COEF : `EQ2_COEF) + 12'(k))
               r = {17'h10000, s.coeff[e][k]};
         end
      end
      if (idx == `FX_STATUS)
         r = {1'b1, 32'(s.eq_ena) << `FX_EQ_STS_LSB};
      if (idx == `CLK_ERR)
         r = {1'b1, 31'h0, s.err};
      if (idx == `CLK_BUDGET)
         r = {17'h10000, s.budget};
      return r;
   endfunction : reg_read

   always_comb
   begin
      next_st = st;
      err_set = 1'b0;
      err_clr = 1'b0;
      any_src = 1'b0;
      hit = 1'b0;
      acc = '0;
      wr_val = '0;
      n_en = '0;
      wr_idx = st.awaddr[13:2];
      rd_idx = AXI_REQ.araddr[13:2];
      wr_old = reg_read(st, wr_idx);
      rd_val = reg_read(st, rd_idx);
      for (int m = 0; m < 7; m++)
         n_en = n_en + 3'(st.en[m]);
      used = 20'(n_en) * 20'(`MIX_COST);

      // Write address and data taken in either order
      if (AXI_REQ.awvalid && !st.aw_have && !st.bvalid)
      begin
         next_st.aw_have = 1'b1;
         next_st.awaddr = AXI_REQ.awaddr;
      end
      if (AXI_REQ.wvalid && !st.w_have && !st.bvalid)
      begin
         next_st.w_have = 1'b1;
         next_st.wdata = AXI_REQ.wdata;
         next_st.wstrb = AXI_REQ.wstrb;
      end
      if (st.bvalid && AXI_REQ.bready)
         next_st.bvalid = 1'b0;

      if (st.aw_have && st.w_have && !st.bvalid)
      begin
         next_st.aw_have = 1'b0;
         next_st.w_have = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = wr_old[32] ? `RESP_OKAY : `RESP_SLVERR;
         for (int b = 0; b < 4; b++)
            wr_val[b*8 +: 8] = st.wstrb[b] ? st.wdata[b*8 +: 8] : wr_old[b*8 +: 8];
         for (int m = 0; m < 7; m++)
         begin
            hit = 1'b0;
            for (int n = 0; n < 4; n++)
            begin
               if (wr_idx == mix_base(m) + 12'(n))
               begin
                  hit = 1'b1;
                  next_st.mix[m][n].src = wr_val[`SRC_LSB +: 8];
                  next_st.mix[m][n].vol = wr_val[`VOL_LSB +: 7];
               end
            end
            any_src = 1'b0;
            for (int n = 0; n < 4; n++)
               any_src = any_src || (next_st.mix[m][n].src != `SRC_SILENCE);
            if (hit && !st.en[m] && any_src)
            begin
               if (used + 20'(`MIX_COST) <= 20'(st.budget))
                  next_st.en[m] = 1'b1;
               else
                  err_set = 1'b1;
            end
            else if (hit && st.en[m] && !any_src)
               next_st.en[m] = 1'b0;
         end
         for (int e = 0; e < 2; e++)
         begin
            if (wr_idx == (e == 0 ? `EQ1_CTL1 : `EQ2_CTL1))
            begin
               next_st.eq_ena[e] = wr_val[0];
               next_st.gain[e][0] = wr_val[15:11];
               next_st.gain[e][1] = wr_val[10:6];
               next_st.gain[e][2] = wr_val[5:1];
            end
            if (wr_idx == (e == 0 ? `EQ1_CTL2 : `EQ2_CTL2))
            begin
               next_st.gain[e][3] = wr_val[15:11];
               next_st.gain[e][4] = wr_val[10:6];
               next_st.eq_b1peak[e] = wr_val[0];
            end
            for (int k = 0; k < `EQ_NCOEF; k++)
            begin
               if (wr_idx == (e == 0 ? `EQ1_COEF : `EQ2_COEF) + 12'(k))
                  next_st.coeff[e][k] = wr_val[15:0];
            end
         end
         if (wr_idx == `CLK_ERR)
            err_clr = st.wstrb[0] && st.wdata[0];
         if (wr_idx == `CLK_BUDGET)
            next_st.budget = wr_val[15:0];
      end
      next_st.err = err_set || (st.err && !err_clr);

      // Read channel
      if (st.rvalid && AXI_REQ.rready)
         next_st.rvalid = 1'b0;
      if (AXI_REQ.arvalid && !st.rvalid)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_val[31:0];
         next_st.rresp = rd_val[32] ? `RESP_OKAY : `RESP_SLVERR;
      end

      // Mixing, one result per sample strobe at whatever rate it runs
      next_st.out_valid = SAMPLE_EN;
      if (SAMPLE_EN)
      begin
         for (int m = 0; m < 7; m++)
         begin
            acc = '0;
            for (int n = 0; n < 4; n++)
            begin
               if (st.en[m])
                  acc = acc + 34'(apply_gain(src_pick(SOURCES, st.mix[m][n].src),
                                             st.mix[m][n].vol));
            end
            if (acc > 34'sh7fffff)
               next_st.mix_out[m] = 24'sh7fffff;
            else if (acc < -34'sh800000)
               next_st.mix_out[m] = -24'sh800000;
            else
               next_st.mix_out[m] = 24'(acc);
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         st <= '0;
         st.budget <= `BUDGET_RST;
         for (int m = 0; m < 7; m++)
         begin
            for (int n = 0; n < 4; n++)
               st.mix[m][n].vol <= `VOL_RST;
         end
         for (int e = 0; e < 2; e++)
         begin
            for (int g = 0; g < 5; g++)
               st.gain[e][g] <= `GAIN_RST;
         end
      end
      else
         st <= next_st;
   end

   always_comb
   begin
      AXI_RSP.awready = !st.aw_have && !st.bvalid;
      AXI_RSP.wready = !st.w_have && !st.bvalid;
      AXI_RSP.bvalid = st.bvalid;
      AXI_RSP.bresp = st.bresp;
      AXI_RSP.arready = !st.rvalid;
      AXI_RSP.rvalid = st.rvalid;
      AXI_RSP.rdata = st.rdata;
      AXI_RSP.rresp = st.rresp;
      for (int e = 0; e < 2; e++)
      begin
         EQ_CFG[e].ena = st.eq_ena[e];
         EQ_CFG[e].mode[0] = st.eq_b1peak[e] ? BAND_PEAK : BAND_SHELF;
         EQ_CFG[e].mode[1] = BAND_PEAK;
         EQ_CFG[e].mode[2] = BAND_PEAK;
         EQ_CFG[e].mode[3] = BAND_PEAK;
         EQ_CFG[e].mode[4] = BAND_SHELF;
         EQ_CFG[e].gain = st.gain[e];
         EQ_CFG[e].coeff = st.coeff[e];
      end
   end

   assign MIX_OUT = st.mix_out;
   assign MIX_OUT_VALID = st.out_valid;
   assign MIX_ENABLED = st.en;
   assign UNDERCLOCKED = st.err;

endmodule : audio_mixer_eq_routing

// File: verification/audio_mixer_eq_routing_sva.sv
// Checker for the mixer routing block ports
// Assumes one clock CLK with synchronous active-high SRST
`timescale 1ns/100ps
module audio_mixer_eq_routing_sva (
   input wire logic                              CLK,
   input wire logic                              SRST,
   input wire audio_mixer_eq_pkg::axil_req_s     AXI_REQ,
   input wire audio_mixer_eq_pkg::axil_rsp_s     AXI_RSP,
   input wire logic                              SAMPLE_EN,
   input wire audio_mixer_eq_pkg::src_bus_s      SOURCES,
   input wire audio_mixer_eq_pkg::sample_t [6:0] MIX_OUT,
   input wire logic                              MIX_OUT_VALID,
   input wire audio_mixer_eq_pkg::eq_cfg_s [1:0] EQ_CFG,
   input wire logic [6:0]                        MIX_ENABLED,
   input wire logic                              UNDERCLOCKED
);
   import audio_mixer_eq_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   a_strobe_valid: assert property (SAMPLE_EN |=> MIX_OUT_VALID)
      else $error("no valid after strobe");
   a_valid_cause: assert property (MIX_OUT_VALID |-> $past(SAMPLE_EN))
      else $error("valid without strobe");
   a_out_hold: assert property (!SAMPLE_EN |=> $stable(MIX_OUT))
      else $error("mixer output moved between strobes");
   for (genvar i = 0; i < 7; i++)
   begin : g_off
      a_off_silent: assert property (SAMPLE_EN && !MIX_ENABLED[i] ##1 !MIX_ENABLED[i]
         |-> MIX_OUT[i] == '0) else $error("disabled mixer not silent");
   end
   a_enable_cause: assert property (!$stable(MIX_ENABLED) |-> $rose(AXI_RSP.bvalid))
      else $error("enables changed without a write");
   a_refuse_keeps: assert property ($rose(UNDERCLOCKED)
      |-> $stable(MIX_ENABLED) && $rose(AXI_RSP.bvalid)) else $error("refusal disturbed paths");
   a_flag_sticky: assert property ($fell(UNDERCLOCKED) |-> $rose(AXI_RSP.bvalid))
      else $error("error flag dropped without a write");
   a_read_answer: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
      else $error("read not answered");
   a_eq_fixed: assert property (EQ_CFG[0].mode[3:1] == 3'b111 && EQ_CFG[1].mode[3:1] == 3'b111
      && EQ_CFG[0].mode[4] == BAND_SHELF && EQ_CFG[1].mode[4] == BAND_SHELF)
      else $error("fixed band modes wrong");
endmodule : audio_mixer_eq_routing_sva

bind audio_mixer_eq_routing audio_mixer_eq_routing_sva u_sva (.CLK(CLK), .SRST(SRST),
   .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .SAMPLE_EN(SAMPLE_EN), .SOURCES(SOURCES),
   .MIX_OUT(MIX_OUT), .MIX_OUT_VALID(MIX_OUT_VALID), .EQ_CFG(EQ_CFG),
   .MIX_ENABLED(MIX_ENABLED), .UNDERCLOCKED(UNDERCLOCKED));

// File: verification/audio_source_model.sv
// Far-side source model: inputs, loopback and serial port channels
// Assumes one shared sample strobe every eight core clocks
`timescale 1ns/100ps
module audio_source_model (
   input  wire logic                         clk,
   input  wire logic                         srst,
   output      audio_mixer_eq_pkg::src_bus_s sources,
   output      logic                         sample_en
);
   import audio_mixer_eq_pkg::*;
   logic [2:0] phase;

   // All sources share one strobe rate
   always_ff @(posedge clk)
   begin
      if (srst)
         phase <= 3'h0;
      else
         phase <= phase + 3'h1;
   end
   assign sample_en = (phase == 3'h7);

   // Each channel carries its select code times 256
   always_comb
   begin
      sources.aec = sample_t'(16'h0800);
      for (int i = 0; i < 4; i++)
         sources.in_path[i] = sample_t'({8'h10 + 8'(i), 8'h00});
      for (int i = 0; i < 8; i++)
         sources.port1[i] = sample_t'({8'h20 + 8'(i), 8'h00});
      for (int i = 0; i < 6; i++)
         sources.port2[i] = sample_t'({8'h28 + 8'(i), 8'h00});
      for (int i = 0; i < 2; i++)
         sources.port3[i] = sample_t'({8'h30 + 8'(i), 8'h00});
   end
endmodule : audio_source_model

// File: verification/audio_mixer_eq_routing_bench.sv
// Self-checking bench for the mixer routing block
// Assumes the source model supplies strobes and code-valued samples
`timescale 1ns/100ps
module audio_mixer_eq_routing_bench;
   import audio_mixer_eq_pkg::*;
   logic          clk;
   logic          srst;
   axil_req_s     req;
   axil_rsp_s     rsp;
   logic          sample_en;
   src_bus_s      sources;
   sample_t [6:0] mix_out;
   logic          mix_valid;
   eq_cfg_s [1:0] eq_cfg;
   logic [6:0]    mix_en;
   logic          uclk;
   int            miscompares = 0;
   int            n_tests = 0;

   audio_mixer_eq_routing uut (.CLK(clk), .SRST(srst), .AXI_REQ(req), .AXI_RSP(rsp),
      .SAMPLE_EN(sample_en), .SOURCES(sources), .MIX_OUT(mix_out), .MIX_OUT_VALID(mix_valid),
      .EQ_CFG(eq_cfg), .MIX_ENABLED(mix_en), .UNDERCLOCKED(uclk));
   audio_source_model src_model (.clk(clk), .srst(srst), .sources(sources),
      .sample_en(sample_en));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic stuck(input string what);
      miscompares++;
      $display("[ERR] %s expected answer seen timeout", what);
      final_report();
   endtask : stuck

   function automatic logic [31:0] mw(input logic [7:0] c, input logic [6:0] v);
      return {8'h00, c, 8'h00, v, 1'b0};
   endfunction : mw

   task automatic wr(input logic [11:0] idx, input logic [31:0] data, input logic [1:0] er);
      int k;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= {idx, 2'b00};
      req.wvalid  <= 1'b1;
      req.wdata   <= data;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      for (k = 0; k < 40; k++)
      begin
         @(posedge clk);
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid)
            break;
      end
      req.bready <= 1'b0;
      if (k == 40)
         stuck("write");
      chk("bresp", 32'(er), 32'(rsp.bresp));
   endtask : wr

   task automatic rd(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
      int k;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr  <= {idx, 2'b00};
      req.rready  <= 1'b1;
      for (k = 0; k < 40; k++)
      begin
         @(posedge clk);
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid)
            break;
      end
      req.rready <= 1'b0;
      if (k == 40)
         stuck("read");
      chk("rdata", ed, rsp.rdata);
      chk("rresp", 32'(er), 32'(rsp.rresp));
   endtask : rd

   task automatic wait_valid;
      int k;
      for (k = 0; k < 40; k++)
      begin
         @(posedge clk);
         if (mix_valid)
            break;
      end
      if (k == 40)
         stuck("sample");
   endtask : wait_valid

   task automatic t_reset;
      rd(12'h680, mw(8'h00, 7'h40), 2'b00);
      rd(12'he10, 32'h6318, 2'b00);
      rd(12'he11, 32'h6300, 2'b00);
      rd(12'ha01, 32'h0100, 2'b00);
      rd(12'h6c0, 32'h0, 2'b10);
      wr(12'h6c0, 32'h1, 2'b10);
      chk("enabled", 32'h0, 32'(mix_en));
   endtask : t_reset

   task automatic t_codes;
      logic [7:0] c;
      logic       ok;
      for (int i = 0; i < 8'h34; i++)
      begin
         c  = 8'(i);
         ok = c == 8'h08 || (c >= 8'h10 && c <= 8'h13) || (c >= 8'h20 && c <= 8'h2d)
              || (c >= 8'h30 && c <= 8'h31);
         wr(12'h780, mw(c, 7'h40), 2'b00);
         wait_valid();
         chk("port three mix", ok ? {16'h0, c, 8'h00} : 32'h0, 32'(mix_out[2]));
      end
      wr(12'h780, mw(8'h00, 7'h40), 2'b00);
   endtask : t_codes

   task automatic t_mix;
      wr(12'h680, mw(8'h10, 7'h40), 2'b00);
      wr(12'h681, mw(8'h20, 7'h34), 2'b00);
      wr(12'h682, mw(8'h31, 7'h40), 2'b00);
      wr(12'h683, mw(8'h08, 7'h40), 2'b00);
      wr(12'h703, mw(8'h27, 7'h40), 2'b00);
      wr(12'h880, mw(8'h28, 7'h40), 2'b00);
      wr(12'h887, mw(8'h2d, 7'h40), 2'b00);
      wait_valid();
      chk("output one mix", 32'h5100, 32'(mix_out[3]));
      chk("port one mix", 32'h2700, 32'(mix_out[0]));
      chk("port two mix", 32'h0, 32'(mix_out[1]));
      chk("eq one mix", 32'h2800, 32'(mix_out[5]));
      chk("eq two mix", 32'h2d00, 32'(mix_out[6]));
      rd(12'h681, mw(8'h20, 7'h34) | 32'h8000, 2'b00);
      chk("enabled", 32'h69, 32'(mix_en));
   endtask : t_mix

   task automatic t_eq;
      wr(12'he10, {16'h0, 5'h03, 5'h15, 5'h18, 1'b1}, 2'b00);
      chk("eq1 gains", {17'h0, 5'h18, 5'h15, 5'h03}, 32'(eq_cfg[0].gain[2:0]));
      chk("eq1 ena", 32'h1, 32'(eq_cfg[0].ena));
      chk("eq1 band1", 32'(BAND_SHELF), 32'(eq_cfg[0].mode[0]));
      wr(12'he27, {16'h0, 5'h07, 5'h19, 6'h01}, 2'b00);
      chk("eq2 gains", {22'h0, 5'h19, 5'h07}, 32'(eq_cfg[1].gain[4:3]));
      chk("eq2 band1", 32'(BAND_PEAK), 32'(eq_cfg[1].mode[0]));
      wr(12'he3a, 32'hbeef, 2'b00);
      wr(12'he24, 32'h1234, 2'b00);
      chk("eq2 coeff", 32'hbeef, 32'(eq_cfg[1].coeff[18]));
      chk("eq1 coeff", 32'h1234, 32'(eq_cfg[0].coeff[18]));
      rd(12'he01, 32'h1000, 2'b00);
   endtask : t_eq

   task automatic t_clock;
      wr(12'ha01, 32'h40, 2'b00);
      wr(12'h688, mw(8'h11, 7'h40), 2'b00);
      chk("underclocked", 32'h1, 32'(uclk));
      chk("enabled", 32'h69, 32'(mix_en));
      rd(12'h688, mw(8'h11, 7'h40), 2'b00);
      wait_valid();
      chk("output one kept", 32'h5100, 32'(mix_out[3]));
      chk("four left off", 32'h0, 32'(mix_out[4]));
      rd(12'ha00, 32'h1, 2'b00);
      wr(12'ha00, 32'h1, 2'b00);
      chk("underclocked", 32'h0, 32'(uclk));
      wr(12'ha01, 32'h100, 2'b00);
      wr(12'h688, mw(8'h11, 7'h40), 2'b00);
      wait_valid();
      chk("four left mix", 32'h1100, 32'(mix_out[4]));
      chk("enabled", 32'h79, 32'(mix_en));
   endtask : t_clock

   initial
   begin
      srst = 1'b1;
      req  = '0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_codes();
      t_mix();
      t_eq();
      t_clock();
      final_report();
   end
endmodule : audio_mixer_eq_routing_bench
